//--- hw/slc_pkg.sv
// constants and types for the receive link parameter register bank
// assumes a byte-wide register port with a 12-bit address
package slc_pkg;
  localparam logic [11:0] ADDR_LANE_COUNT = 12'h453;
  localparam logic [11:0] ADDR_OCTETS_M1 = 12'h454;
  localparam logic [11:0] ADDR_FRAMES_MF = 12'h455;
  localparam logic [11:0] ADDR_CONVERTERS = 12'h456;
  localparam logic [11:0] ADDR_RESOLUTION = 12'h457;
  localparam logic [11:0] ADDR_SUBCLASS = 12'h458;
  localparam logic [11:0] ADDR_VERSION = 12'h459;
  localparam logic [11:0] ADDR_HIGH_DENSITY = 12'h45a;
  localparam logic [11:0] ADDR_DESKEW = 12'h46c;
  localparam logic [11:0] ADDR_OCTETS_DIRECT = 12'h476;
  localparam logic [11:0] ADDR_LANE_ENABLE = 12'h47d;
  localparam logic [11:0] ADDR_LINK_MODE = 12'h300;
  localparam logic [11:0] ADDR_STATUS = 12'h030;
  localparam int SCRAMBLE_BIT = 7;
  localparam int HD_BIT = 7;
  localparam int ST_COMBO_BIT = 3;
  localparam int ST_MF_BIT = 2;
  localparam int ST_SUBCLASS_BIT = 1;
  localparam int SINGLE_LINK_BIT = 3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_LINK_MODE = 8'h00;
  localparam logic [4:0] FIELD_RES_M1 = 5'h0f;
  localparam logic [4:0] FIELD_NP_M1 = 5'h0f;
  localparam logic [2:0] FIELD_VERSION = 3'h1;
  localparam logic [4:0] FIELD_MF_32 = 5'h1f;
  localparam logic [4:0] FIELD_MF_16 = 5'h0f;
  localparam logic [2:0] SUBCLASS_0 = 3'h0;
  localparam logic [2:0] SUBCLASS_1 = 3'h1;
  localparam logic [7:0] MASK_MODE11 = 8'hff;
  localparam logic [7:0] MASK_MODE12 = 8'h33;
  localparam logic [7:0] MASK_MODE13 = 8'h11;

  typedef enum logic [1:0] {MODE_NONE = 2'h0, MODE_11 = 2'h1, MODE_12 = 2'h3,
    MODE_13 = 2'h2} slc_mode_type;

  typedef struct packed {
    logic scramble_en;
    logic [4:0] lanes_m1;
    logic [7:0] octets_m1;
    logic [7:0] octets;
    logic [4:0] frames_mf_m1;
    logic [7:0] converters_m1;
    logic [2:0] subclass;
    logic [4:0] samples_m1;
    logic high_density;
    logic [7:0] deskew_mask;
    logic [7:0] enable_mask;
  } slc_link_cfg_type;
endpackage : slc_pkg

//--- hw/slc_serial_rx_link_param_config.sv
// register bank holding the receive link parameters for single-link modes 11 to 13
// assumes a decoded serial-port byte access: one-cycle wr_en/rd_en with address
// Functional notes
// R01 - bit 7 of lane-count register enables descrambling; must match transmitter
// R02 - lane-count field is lanes minus one: 3, 1, 0 give four, two, one
// R03 - first octets register is frame size minus one
// R04 - second octets register holds frame size directly: 1 or 2
// R05 - multiframe field is frames minus one; one-octet modes need 0x1f
// R06 - one-lane two-octet mode accepts multiframe 0x0f or 0x1f
// R07 - receiver programmed with one converter and half lanes of transmitter
// R08 - control-bits field bits 7:6 must be zero
// R09 - resolution field is 0x0f, sixteen bits, always
// R10 - subclass field selects subclass 0 or 1, matching transmitter
// R11 - sample bits field must be 0xf, sixteen bits per sample
// R12 - version field must be 1 for this protocol version
// R13 - samples field is samples minus one; 1 gives two in mode 11
// R14 - modes 12 and 13 need samples field zero, register 0x20
// R15 - high-density flag set in one-octet modes 11 and 12
// R16 - high-density flag cleared in two-octet mode 13
// R17 - control words per frame field must be zero
// R18 - mode 11 deskew and enable masks are 0xff
// R19 - mode 12 deskew and enable masks are 0x33
// R20 - mode 13 deskew and enable masks are 0x11
// R21 - parameters take effect only when link mode register selects single link
// R22 - lane deskewed when deskew bit set, then enabled when enable bit set
// R23 - status flags bad combination bit 3, multiframe bit 2, subclass bit 1
// R24 - registers hold and read back last written value until reset
`timescale 1ns/1ns
`default_nettype none
module slc_serial_rx_link_param_config
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output slc_pkg::slc_link_cfg_type link_cfg,
  output logic link_cfg_valid,
  output slc_pkg::slc_mode_type link_mode,
  output logic [7:0] lane_deskew,
  output logic [7:0] lane_enable
);
  import slc_pkg::*;

  logic [7:0] lane_count_scramble_r;
  logic [7:0] octets_per_frame_minus1_r;
  logic [7:0] frames_per_multiframe_r;
  logic [7:0] converters_per_link_r;
  logic [7:0] ctrl_bits_resolution_r;
  logic [7:0] subclass_sample_bits_r;
  logic [7:0] version_samples_per_frame_r;
  logic [7:0] high_density_ctrl_words_r;
  logic [7:0] lane_deskew_mask_r;
  logic [7:0] octets_per_frame_direct_r;
  logic [7:0] lane_enable_mask_r;
  logic [7:0] link_mode_r;
  logic [7:0] status_r;
  logic [7:0] reg_rdata_r;
  logic reg_rd_valid_r;
  slc_link_cfg_type link_cfg_r;
  logic link_cfg_valid_r;
  slc_mode_type mode_sel_r;
  logic [7:0] lane_deskew_r;
  logic [7:0] lane_enable_r;

  function automatic logic wr_hit(input logic [11:0] addr, input logic [11:0] target,
                                  input logic en);
    wr_hit = en && (addr == target);
  endfunction : wr_hit

  // one strobe per writable register; writes to any other address, status included, are dropped
  wire logic wr_lane_count = wr_hit(reg_addr, ADDR_LANE_COUNT, reg_wr_en);
  wire logic wr_octets_m1 = wr_hit(reg_addr, ADDR_OCTETS_M1, reg_wr_en);
  wire logic wr_frames_mf = wr_hit(reg_addr, ADDR_FRAMES_MF, reg_wr_en);
  wire logic wr_converters = wr_hit(reg_addr, ADDR_CONVERTERS, reg_wr_en);
  wire logic wr_resolution = wr_hit(reg_addr, ADDR_RESOLUTION, reg_wr_en);
  wire logic wr_subclass = wr_hit(reg_addr, ADDR_SUBCLASS, reg_wr_en);
  wire logic wr_version = wr_hit(reg_addr, ADDR_VERSION, reg_wr_en);
  wire logic wr_high_density = wr_hit(reg_addr, ADDR_HIGH_DENSITY, reg_wr_en);
  wire logic wr_deskew = wr_hit(reg_addr, ADDR_DESKEW, reg_wr_en);
  wire logic wr_octets_direct = wr_hit(reg_addr, ADDR_OCTETS_DIRECT, reg_wr_en);
  wire logic wr_lane_enable = wr_hit(reg_addr, ADDR_LANE_ENABLE, reg_wr_en);
  wire logic wr_link_mode = wr_hit(reg_addr, ADDR_LINK_MODE, reg_wr_en); // R21

  // field views
  wire logic [4:0] lanes_m1 = lane_count_scramble_r[4:0]; // R02
  wire logic [4:0] mf_m1 = frames_per_multiframe_r[4:0]; // R05
  wire logic [2:0] subclass = subclass_sample_bits_r[7:5]; // R10
  wire logic [4:0] samples_m1 = version_samples_per_frame_r[4:0]; // R13
  wire logic hd = high_density_ctrl_words_r[HD_BIT];
  wire logic single_link = link_mode_r[SINGLE_LINK_BIT];

  // mode recognised from lanes, octets, samples and the high-density flag
  wire logic is_m11 = (lanes_m1 == 5'h03) && (octets_per_frame_minus1_r == 8'h00)
                      && (samples_m1 == 5'h01) && hd; // R13 R15
  wire logic is_m12 = (lanes_m1 == 5'h01) && (octets_per_frame_minus1_r == 8'h00)
                      && (samples_m1 == 5'h00) && hd; // R14 R15
  wire logic is_m13 = (lanes_m1 == 5'h00) && (octets_per_frame_minus1_r == 8'h01)
                      && (samples_m1 == 5'h00) && !hd; // R14 R16
  wire logic octets_agree = (octets_per_frame_direct_r
                             == (octets_per_frame_minus1_r + 8'h01)); // R03 R04
  wire logic fixed_ok = (converters_per_link_r == 8'h00) // R07
                        && (ctrl_bits_resolution_r[7:6] == 2'h0) // R08
                        && (ctrl_bits_resolution_r[4:0] == FIELD_RES_M1) // R09
                        && (subclass_sample_bits_r[4:0] == FIELD_NP_M1) // R11
                        && (version_samples_per_frame_r[7:5] == FIELD_VERSION) // R12
                        && (high_density_ctrl_words_r[4:0] == 5'h00); // R17
  wire logic [7:0] mode_mask = is_m11 ? MASK_MODE11 : is_m12 ? MASK_MODE12 : MASK_MODE13;
  wire logic masks_ok = (lane_deskew_mask_r == mode_mask)
                        && (lane_enable_mask_r == mode_mask); // R18 R19 R20
  wire logic mode_hit = is_m11 || is_m12 || is_m13;
  wire logic combo_bad = !(mode_hit && octets_agree && fixed_ok && masks_ok); // R23
  // one-octet modes only accept 32 frames; mode 13 also 16
  wire logic mf_bad = is_m13 ? !((mf_m1 == FIELD_MF_16) || (mf_m1 == FIELD_MF_32))
                             : (mf_m1 != FIELD_MF_32); // R05 R06
  wire logic sub_bad = !((subclass == SUBCLASS_0) || (subclass == SUBCLASS_1)); // R10
  wire logic [7:0] status_nxt = {4'h0, combo_bad, mf_bad, sub_bad, 1'b0}; // R23
  // outside single link or with a bad set the deframer gets no valid, mode or lanes; link_cfg still follows the registers
  wire logic cfg_ok = single_link && !combo_bad && !mf_bad && !sub_bad; // R21
  wire slc_mode_type mode_nxt = !cfg_ok ? MODE_NONE : is_m11 ? MODE_11
                                : is_m12 ? MODE_12 : MODE_13; // R21

  slc_link_cfg_type cfg_nxt;
  assign cfg_nxt.scramble_en = lane_count_scramble_r[SCRAMBLE_BIT]; // R01
  assign cfg_nxt.lanes_m1 = lanes_m1; // R02
  assign cfg_nxt.octets_m1 = octets_per_frame_minus1_r; // R03
  assign cfg_nxt.octets = octets_per_frame_direct_r; // R04
  assign cfg_nxt.frames_mf_m1 = mf_m1; // R05
  assign cfg_nxt.converters_m1 = converters_per_link_r; // R07
  assign cfg_nxt.subclass = subclass; // R10
  assign cfg_nxt.samples_m1 = samples_m1; // R13
  assign cfg_nxt.high_density = hd; // R15
  assign cfg_nxt.deskew_mask = lane_deskew_mask_r; // R22
  assign cfg_nxt.enable_mask = lane_enable_mask_r; // R22

  // deskew runs first; a lane is enabled only once it is in the deskew set
  wire logic [7:0] deskew_nxt = cfg_ok ? lane_deskew_mask_r : 8'h00; // R22
  wire logic [7:0] enable_nxt = (cfg_ok ? lane_enable_mask_r : 8'h00)
                                & lane_deskew_r; // R22

  wire logic [7:0] rdata_nxt =
    (reg_addr == ADDR_LANE_COUNT) ? lane_count_scramble_r :
    (reg_addr == ADDR_OCTETS_M1) ? octets_per_frame_minus1_r :
    (reg_addr == ADDR_FRAMES_MF) ? frames_per_multiframe_r :
    (reg_addr == ADDR_CONVERTERS) ? converters_per_link_r :
    (reg_addr == ADDR_RESOLUTION) ? ctrl_bits_resolution_r :
    (reg_addr == ADDR_SUBCLASS) ? subclass_sample_bits_r :
    (reg_addr == ADDR_VERSION) ? version_samples_per_frame_r :
    (reg_addr == ADDR_HIGH_DENSITY) ? high_density_ctrl_words_r :
    (reg_addr == ADDR_DESKEW) ? lane_deskew_mask_r :
    (reg_addr == ADDR_OCTETS_DIRECT) ? octets_per_frame_direct_r :
    (reg_addr == ADDR_LANE_ENABLE) ? lane_enable_mask_r :
    (reg_addr == ADDR_LINK_MODE) ? link_mode_r :
    (reg_addr == ADDR_STATUS) ? status_r : 8'h00; // R24

  // configuration storage, plain read-back; one short block per register
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lane_count_scramble_r <= RST_ZERO;
    end
    else if (wr_lane_count)
    begin
      lane_count_scramble_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      octets_per_frame_minus1_r <= RST_ZERO;
    end
    else if (wr_octets_m1)
    begin
      octets_per_frame_minus1_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      frames_per_multiframe_r <= RST_ZERO;
    end
    else if (wr_frames_mf)
    begin
      frames_per_multiframe_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      converters_per_link_r <= RST_ZERO;
    end
    else if (wr_converters)
    begin
      converters_per_link_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_bits_resolution_r <= RST_ZERO;
    end
    else if (wr_resolution)
    begin
      ctrl_bits_resolution_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      subclass_sample_bits_r <= RST_ZERO;
    end
    else if (wr_subclass)
    begin
      subclass_sample_bits_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      version_samples_per_frame_r <= RST_ZERO;
    end
    else if (wr_version)
    begin
      version_samples_per_frame_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      high_density_ctrl_words_r <= RST_ZERO;
    end
    else if (wr_high_density)
    begin
      high_density_ctrl_words_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lane_deskew_mask_r <= RST_ZERO;
    end
    else if (wr_deskew)
    begin
      lane_deskew_mask_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      octets_per_frame_direct_r <= RST_ZERO;
    end
    else if (wr_octets_direct)
    begin
      octets_per_frame_direct_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lane_enable_mask_r <= RST_ZERO;
    end
    else if (wr_lane_enable)
    begin
      lane_enable_mask_r <= reg_wdata; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      link_mode_r <= RST_LINK_MODE;
    end
    else if (wr_link_mode)
    begin
      link_mode_r <= reg_wdata; // R21
    end
  end

  // derived state, one cycle behind the stored values; lane enable also waits a cycle on registered deskew
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status_r <= RST_ZERO;
    end
    else
    begin
      status_r <= status_nxt; // R23
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata_r <= RST_ZERO;
    end
    else
    begin
      reg_rdata_r <= reg_rd_en ? rdata_nxt : 8'h00; // R24
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rd_valid_r <= 1'b0;
    end
    else
    begin
      reg_rd_valid_r <= reg_rd_en;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      link_cfg_r <= '0;
    end
    else
    begin
      link_cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      link_cfg_valid_r <= 1'b0;
    end
    else
    begin
      link_cfg_valid_r <= cfg_ok; // R21
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mode_sel_r <= MODE_NONE;
    end
    else
    begin
      mode_sel_r <= mode_nxt; // R21
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lane_deskew_r <= RST_ZERO;
    end
    else
    begin
      lane_deskew_r <= deskew_nxt; // R22
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      lane_enable_r <= RST_ZERO;
    end
    else
    begin
      lane_enable_r <= enable_nxt; // R22
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign reg_rd_valid = reg_rd_valid_r;
  assign link_cfg = link_cfg_r;
  assign link_cfg_valid = link_cfg_valid_r;
  assign link_mode = mode_sel_r;
  assign lane_deskew = lane_deskew_r;
  assign lane_enable = lane_enable_r;
endmodule : slc_serial_rx_link_param_config
`default_nettype wire

//--- verification/slc_sva.sv
// port assertions for the link parameter register bank
// assumes a bind onto slc_serial_rx_link_param_config
`timescale 1ns/1ns
`default_nettype none
module slc_sva
  import slc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire slc_pkg::slc_link_cfg_type link_cfg,
  input wire logic link_cfg_valid,
  input wire slc_pkg::slc_mode_type link_mode,
  input wire logic [7:0] lane_deskew,
  input wire logic [7:0] lane_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rd_valid && reg_rdata == 8'h00)
    else $error("read data without request");
  // deskew and valid leave on the same edge, so no lag is allowed
  AST_DESKEW_GATE: assert property (!link_cfg_valid |-> lane_deskew == 8'h00)
    else $error("lanes deskewed while config invalid");
  AST_ENABLE_AFTER: assert property ((lane_enable & ~$past(lane_deskew)) == 8'h00)
    else $error("lane enabled before deskew");
  AST_MASK_M11: assert property (link_cfg_valid [*2] ##0 link_mode == MODE_11
    |-> lane_deskew == MASK_MODE11)
    else $error("mode 11 mask wrong");
  AST_MASK_M12: assert property (link_cfg_valid [*2] ##0 link_mode == MODE_12
    |-> lane_deskew == MASK_MODE12)
    else $error("mode 12 mask wrong");
  AST_MASK_M13: assert property (link_cfg_valid [*2] ##0 link_mode == MODE_13
    |-> lane_deskew == MASK_MODE13)
    else $error("mode 13 mask wrong");
  AST_HD_FLAG: assert property (link_cfg_valid |->
    link_cfg.high_density == (link_mode != MODE_13))
    else $error("high-density flag disagrees with mode");
endmodule : slc_sva
`default_nettype wire

//--- verification/slc_tx_model.sv
// far-end transmitter view of the programmed link parameters
// assumes link_cfg from the register bank on the same clock
`timescale 1ns/1ns
`default_nettype none
module slc_tx_model
  import slc_pkg::*;
(
  input wire logic sys_clk,
  input wire slc_pkg::slc_link_cfg_type link_cfg,
  input wire logic link_cfg_valid,
  output logic [5:0] tx_lanes,
  output logic [1:0] tx_conv,
  output logic tx_scr,
  output logic [2:0] tx_subclass
);
  // real link carries twice the lanes and two converters
  always_ff @(posedge sys_clk)
    if (link_cfg_valid)
    begin
      tx_lanes <= {link_cfg.lanes_m1, 1'b0} + 6'h02;
      tx_conv <= 2'h2;
      tx_scr <= link_cfg.scramble_en;
      tx_subclass <= link_cfg.subclass;
    end
endmodule : slc_tx_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the link parameter register bank
// assumes slc_pkg, slc_tx_model and slc_sva compiled before it
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import slc_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_rdata, lane_deskew, lane_enable;
  logic reg_rd_valid, link_cfg_valid, tx_scr;
  slc_link_cfg_type link_cfg;
  slc_mode_type link_mode;
  logic [5:0] tx_lanes;
  logic [1:0] tx_conv;
  logic [2:0] tx_subclass;
  int miscompares = 0;
  int comparisons = 0;
  logic [15:0] expq[$];
  logic [11:0] addrs [11] = '{12'h453, 12'h454, 12'h455, 12'h456, 12'h457, 12'h458,
    12'h459, 12'h45a, 12'h46c, 12'h476, 12'h47d};
  logic [87:0] modes [3] = '{88'h03001f000f0f2180ff01ff, 88'h01001f000f0f2080330133,
    88'h00011f000f0f2000110211};
  slc_mode_type mexp [3] = '{MODE_11, MODE_12, MODE_13};
  logic [7:0] mk [3] = '{8'hff, 8'h33, 8'h11};
  logic [11:0] bad_a [3] = '{12'h458, 12'h455, 12'h456};
  logic [7:0] bad_d [3] = '{8'h4f, 8'h07, 8'h01};
  logic [7:0] good_d [3] = '{8'h0f, 8'h1f, 8'h00};
  logic [7:0] bad_st [3] = '{8'h02, 8'h04, 8'h08};
  always #4 sys_clk = ~sys_clk;
  slc_serial_rx_link_param_config dut_u (.sys_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_rd_valid, .link_cfg, .link_cfg_valid,
    .link_mode, .lane_deskew, .lane_enable);
  slc_tx_model tx_u (.sys_clk, .link_cfg, .link_cfg_valid, .tx_lanes, .tx_conv,
    .tx_scr, .tx_subclass);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one bus cycle: drive after the edge, hold through the next edge
  task automatic op(input logic w, input logic r, input logic [11:0] a,
    input logic [7:0] d);
    reg_wr_en = w;
    reg_rd_en = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
  endtask : op
  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 12'h000, 8'h00);
  endtask : idle
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    expq.push_back({m, e & m});
    op(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // sampled mid-cycle; an answer with no note left is a stray answer
  always @(negedge sys_clk)
    if (reg_rd_valid === 1'b1)
    begin
      logic [15:0] n;
      if (expq.size() == 0)
        chk(16'h0001, 16'h0000);
      else
      begin
        n = expq.pop_front();
        chk({8'h00, reg_rdata & n[15:8]}, {8'h00, n[7:0]});
      end
    end
  initial
  begin
    #40000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    logic [87:0] v;
    void'($urandom(32'h1250));
    repeat (5) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 11; i++) rd(addrs[i], 8'hff, 8'h00);
    rd(12'h300, 8'hff, 8'h00);
    rd(12'h123, 8'hff, 8'h00);
    $display("test reset values done");
    for (int m = 0; m < 3; m++)
    begin
      v = modes[m];
      v[87] = 1'($urandom);
      v[47:45] = {2'b00, 1'($urandom)};
      if (m == 2) v[68] = 1'($urandom);
      for (int i = 0; i < 11; i++) op(1'b1, 1'b0, addrs[i], v[87-8*i -: 8]);
      op(1'b1, 1'b0, 12'h300, 8'h08);
      for (int i = 0; i < 11; i++) rd(addrs[i], 8'hff, v[87-8*i -: 8]);
      rd(12'h030, 8'h0e, 8'h00);
      idle(4);
      chk({lane_deskew, lane_enable}, {mk[m], mk[m]});
      chk({14'h0000, link_mode}, {14'h0000, mexp[m]});
      chk({3'h0, link_cfg_valid, tx_scr, tx_subclass, tx_lanes, tx_conv},
        {3'h0, 1'b1, v[87], v[47:45], 6'(8 >> m), 2'h2});
      chk({link_cfg.high_density, link_cfg.samples_m1, link_cfg.frames_mf_m1,
        link_cfg.octets[4:0]}, {v[31], v[36:32], v[68:64], v[12:8]});
      $display("test mode %0d done", m + 11);
    end
    for (int e = 0; e < 3; e++)
    begin
      op(1'b1, 1'b0, bad_a[e], bad_d[e]);
      idle(4);
      rd(12'h030, 8'h0e, bad_st[e]);
      chk({7'h00, link_cfg_valid, lane_deskew}, 16'h0000);
      op(1'b1, 1'b0, bad_a[e], good_d[e]);
      $display("test bad setting %0d done", e);
    end
    op(1'b1, 1'b0, 12'h300, 8'h00);
    idle(4);
    chk({link_cfg_valid, lane_deskew, lane_enable[6:0]}, 16'h0000);
    chk(16'(expq.size()), 16'h0000);
    $display("test link mode off done");
    sys_rst = 1'b1;
    idle(2);
    sys_rst = 1'b0;
    rd(12'h47d, 8'hff, 8'h00);
    rd(12'h300, 8'hff, 8'h00);
    idle(2);
    chk(16'(expq.size()), 16'h0000);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : testbench
bind slc_serial_rx_link_param_config slc_sva chk_u (.sys_clk, .sys_rst, .reg_rd_en,
  .reg_rdata, .reg_rd_valid, .link_cfg, .link_cfg_valid, .link_mode, .lane_deskew,
  .lane_enable);
`default_nettype wire
